// ### src/thermal_cfg.svh
// Register offsets, field positions and reset values of the config bank
`ifndef THERMAL_CFG_SVH
`define THERMAL_CFG_SVH

`define ADDR_LOCAL_OFFSET 8'h71
`define ADDR_REMOTE_TWO_OFFSET 8'h72
`define ADDR_CONFIG_TWO 8'h73
`define ADDR_ALERT_MASK_ONE 8'h74

`define RST_LOCAL_OFFSET 8'h00
`define RST_REMOTE_TWO_OFFSET 8'h00
`define RST_CONFIG_TWO 8'h00
`define RST_ALERT_MASK_ONE 8'h00
`define RDATA_UNMAPPED 8'h00

`define CONFIG_TWO_WRITABLE 8'hF1
`define ALERT_MASK_ONE_WRITABLE 8'hF6

`define C2_PRESENCE_EN 0
`define C2_FLAG_LO 1
`define C2_FLAG_HI 3
`define C2_AVG_OFF 4
`define C2_CORE_SUPPLY_ATTENUATOR_BYPASS_BYPASS 5
`define C2_SINGLE 6
`define C2_HALT 7

`define M1_CORE 1
`define M1_MAIN 2
`define M1_REMOTE_ONE 4
`define M1_LOCAL 5
`define M1_REMOTE_TWO 6
`define M1_STATUS_TWO_OVERRIDE 7

`define SEL_CORE 3'h1
`define SEL_MAIN 3'h2
`define SEL_REMOTE_ONE 3'h5
`define SEL_LOCAL 3'h6
`define SEL_REMOTE_TWO 3'h7

`endif

// ### src/thermal_pkg.sv
// State types of the thermal config bank
package thermal_pkg;

	typedef struct packed {
		logic [7:0] local_offset;
		logic [7:0] remote_two_offset;
		logic [7:0] config_two;
		logic [7:0] alert_mask;
		logic [2:0] fan_meta;
		logic [2:0] fan_sync;
		logic [7:0] rdata;
		logic rvalid;
		logic alert_n;
		logic [3:0] fan_drive;
		logic [2:0] sel;
		logic sel_valid;
	} bank_state_t;

endpackage

// ### src/offset_adder.sv
// Signed half-degree offset applied to one temperature reading
`timescale 1ns/100ps
`default_nettype none

module offset_adder #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Reading and offset
	input wire logic [WIDTH-1:0] raw,
	input wire logic [7:0] offset,
	// Corrected reading
	output logic [WIDTH-1:0] result
);

	typedef struct packed {
		logic [WIDTH-1:0] result;
	} adder_state_t;

	adder_state_t state_r;
	adder_state_t state_nxt;
	logic signed [WIDTH+2:0] sum;

	// Reading LSB is a quarter degree, so one offset step is two LSBs
	always_comb begin
		sum = $signed({3'h0, raw}) +
			$signed({{(WIDTH-6){offset[7]}}, offset, 1'b0});
		state_nxt = state_r;
		if (sum[WIDTH+2]) begin
			state_nxt.result = '0;
		end else if (sum[WIDTH+1:WIDTH] != 2'h0) begin
			state_nxt.result = '1;
		end else begin
			state_nxt.result = sum[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign result = state_r.result;

	// Clamping is left out of the check by keeping the reading mid-range
	property p_offset_sum;
		@(posedge clk) disable iff (reset)
		(int'(raw) >= 256 && int'(raw) <= (1 << WIDTH) - 257) |=>
			int'(result) == int'($past(raw)) +
				2 * int'($signed($past(offset)));
	endproperty
	a_offset_sum: assert property (p_offset_sum)
		else $error("offset sum wrong");

endmodule
`default_nettype wire

// ### src/thermal_config_bank.sv
// Offset, configuration-2 and alert-mask register bank with its effects
`timescale 1ns/100ps
`default_nettype none
`include "thermal_cfg.svh"

module thermal_config_bank #(
	parameter int TEMP_WIDTH = 10
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Register port from the management-bus front end
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	// Lock bit of configuration register 1
	input wire logic CFG1_LOCK,
	// Four-wire fan sense, asynchronous
	input wire logic [2:0] FAN_FOUR_WIRE,
	// Temperature path
	input wire logic [TEMP_WIDTH-1:0] LOCAL_TEMP_RAW,
	input wire logic [TEMP_WIDTH-1:0] REMOTE_TWO_TEMP_RAW,
	output logic [TEMP_WIDTH-1:0] LOCAL_TEMP,
	output logic [TEMP_WIDTH-1:0] REMOTE_TWO_TEMP,
	// Conversion control
	input wire logic [2:0] TACHOMETER_ONE_SEL,
	output logic AVERAGING_DISABLE,
	output logic CORE_SUPPLY_ATTENUATOR_BYPASS,
	output logic SINGLE_CHANNEL_MODE,
	output logic [2:0] SINGLE_CHANNEL_SEL,
	output logic SINGLE_CHANNEL_SEL_VALID,
	// Fan drive
	input wire logic [3:0] FAN_DRIVE_IN,
	input wire logic PWM_POLARITY_FLIP,
	output logic LOW_POWER_HALT,
	output logic [3:0] FAN_DRIVE,
	// Alert sources
	input wire logic [6:0] LIMIT_FLAGS,
	input wire logic [7:0] STATUS_TWO_FLAGS,
	input wire logic [7:0] ALERT_MASK_TWO,
	output logic SMBALERT_N
);

	thermal_pkg::bank_state_t state_r;
	thermal_pkg::bank_state_t state_nxt;
	logic limit_alert;
	logic status_two_alert;
	logic [7:0] config_view;

	// Only the five documented channel codes are valid
	function automatic logic code_valid(input logic [2:0] code);
		code_valid = (code == `SEL_CORE) || (code == `SEL_MAIN) ||
			(code == `SEL_REMOTE_ONE) || (code == `SEL_LOCAL) ||
			(code == `SEL_REMOTE_TWO);
	endfunction

	// Presence flags read zero unless detection is enabled
	always_comb begin
		config_view = state_r.config_two;
		if (state_r.config_two[`C2_PRESENCE_EN]) begin
			config_view[`C2_FLAG_HI:`C2_FLAG_LO] = state_r.fan_sync;
		end else begin
			config_view[`C2_FLAG_HI:`C2_FLAG_LO] = 3'h0;
		end
	end

	// Mask bits 0 and 3 are not stored, so those flags always alert
	always_comb begin
		limit_alert = |(LIMIT_FLAGS & ~state_r.alert_mask[6:0]);
		if (state_r.alert_mask[`M1_STATUS_TWO_OVERRIDE]) begin
			status_two_alert = |(STATUS_TWO_FLAGS & ~ALERT_MASK_TWO);
		end else begin
			status_two_alert = |STATUS_TWO_FLAGS;
		end
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.rvalid = 1'b0;
		state_nxt.fan_meta = FAN_FOUR_WIRE;
		state_nxt.fan_sync = state_r.fan_meta;

		// Locked registers keep their value until the next power-up
		if (REG_WR && !CFG1_LOCK) begin
			if (REG_ADDR == `ADDR_LOCAL_OFFSET) begin
				state_nxt.local_offset = REG_WDATA;
			end else if (REG_ADDR == `ADDR_REMOTE_TWO_OFFSET) begin
				state_nxt.remote_two_offset = REG_WDATA;
			end else if (REG_ADDR == `ADDR_CONFIG_TWO) begin
				state_nxt.config_two = REG_WDATA & `CONFIG_TWO_WRITABLE;
			end else if (REG_ADDR == `ADDR_ALERT_MASK_ONE) begin
				state_nxt.alert_mask = REG_WDATA & `ALERT_MASK_ONE_WRITABLE;
			end
		end

		// A read in the write cycle returns the old contents
		if (REG_RD) begin
			state_nxt.rvalid = 1'b1;
			if (REG_ADDR == `ADDR_LOCAL_OFFSET) begin
				state_nxt.rdata = state_r.local_offset;
			end else if (REG_ADDR == `ADDR_REMOTE_TWO_OFFSET) begin
				state_nxt.rdata = state_r.remote_two_offset;
			end else if (REG_ADDR == `ADDR_CONFIG_TWO) begin
				state_nxt.rdata = config_view;
			end else if (REG_ADDR == `ADDR_ALERT_MASK_ONE) begin
				state_nxt.rdata = state_r.alert_mask;
			end else begin
				state_nxt.rdata = `RDATA_UNMAPPED;
			end
		end

		state_nxt.alert_n = !(limit_alert || status_two_alert);

		if (state_r.config_two[`C2_HALT]) begin
			state_nxt.fan_drive = {4{PWM_POLARITY_FLIP}};
		end else begin
			state_nxt.fan_drive = FAN_DRIVE_IN;
		end

		// Reserved codes leave the converter without a target
		state_nxt.sel = TACHOMETER_ONE_SEL;
		state_nxt.sel_valid = state_r.config_two[`C2_SINGLE] &&
			code_valid(TACHOMETER_ONE_SEL);
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state_r <= '0;
			state_r.local_offset <= `RST_LOCAL_OFFSET;
			state_r.remote_two_offset <= `RST_REMOTE_TWO_OFFSET;
			state_r.config_two <= `RST_CONFIG_TWO;
			state_r.alert_mask <= `RST_ALERT_MASK_ONE;
			state_r.alert_n <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	offset_adder #(
		.WIDTH(TEMP_WIDTH)
	) local_adder (
		.clk(CLK),
		.reset(RESET),
		.raw(LOCAL_TEMP_RAW),
		.offset(state_r.local_offset),
		.result(LOCAL_TEMP)
	);

	offset_adder #(
		.WIDTH(TEMP_WIDTH)
	) remote_two_adder (
		.clk(CLK),
		.reset(RESET),
		.raw(REMOTE_TWO_TEMP_RAW),
		.offset(state_r.remote_two_offset),
		.result(REMOTE_TWO_TEMP)
	);

	assign REG_RDATA = state_r.rdata;
	assign REG_RVALID = state_r.rvalid;
	assign AVERAGING_DISABLE = state_r.config_two[`C2_AVG_OFF];
	assign CORE_SUPPLY_ATTENUATOR_BYPASS =
		state_r.config_two[`C2_CORE_SUPPLY_ATTENUATOR_BYPASS_BYPASS];
	assign SINGLE_CHANNEL_MODE = state_r.config_two[`C2_SINGLE];
	assign SINGLE_CHANNEL_SEL = state_r.sel;
	assign SINGLE_CHANNEL_SEL_VALID = state_r.sel_valid;
	assign LOW_POWER_HALT = state_r.config_two[`C2_HALT];
	assign FAN_DRIVE = state_r.fan_drive;
	assign SMBALERT_N = state_r.alert_n;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	sequence s_locked_write;
		CFG1_LOCK && REG_WR;
	endsequence

	property p_lock_freeze;
		s_locked_write |=> $stable(state_r.local_offset) &&
			$stable(state_r.remote_two_offset) &&
			$stable(state_r.config_two) && $stable(state_r.alert_mask);
	endproperty
	a_lock_freeze: assert property (p_lock_freeze)
		else $error("locked register changed on write");

	property p_open_write;
		(!CFG1_LOCK && REG_WR && REG_ADDR == `ADDR_REMOTE_TWO_OFFSET)
			|=> state_r.remote_two_offset == $past(REG_WDATA);
	endproperty
	a_open_write: assert property (p_open_write)
		else $error("unlocked offset write lost");

	property p_flags_hidden;
		(REG_RD && REG_ADDR == `ADDR_CONFIG_TWO &&
			!state_r.config_two[`C2_PRESENCE_EN]) |=>
			REG_RVALID && REG_RDATA[3:1] == 3'h0;
	endproperty
	a_flags_hidden: assert property (p_flags_hidden)
		else $error("presence flags visible while disabled");

	sequence s_pins_steady;
		$stable(FAN_FOUR_WIRE) [*3];
	endsequence

	property p_flags_follow;
		s_pins_steady ##0 (REG_RD && REG_ADDR == `ADDR_CONFIG_TWO &&
			state_r.config_two[`C2_PRESENCE_EN]) |=>
			REG_RDATA[3:1] == $past(FAN_FOUR_WIRE);
	endproperty
	a_flags_follow: assert property (p_flags_follow)
		else $error("presence flags do not follow pins");

	// A write clearing the halt bit must not trip the drive check
	property p_halt_drive;
		state_r.config_two[`C2_HALT] |-> LOW_POWER_HALT ##1
			FAN_DRIVE == {4{$past(PWM_POLARITY_FLIP)}};
	endproperty
	a_halt_drive: assert property (p_halt_drive)
		else $error("fan drive not off during halt");

	property p_drive_pass;
		!state_r.config_two[`C2_HALT] |=> FAN_DRIVE == $past(FAN_DRIVE_IN);
	endproperty
	a_drive_pass: assert property (p_drive_pass)
		else $error("fan drive not passed through");

	property p_mode_bits;
		(!CFG1_LOCK && REG_WR && REG_ADDR == `ADDR_CONFIG_TWO) |=>
			AVERAGING_DISABLE == $past(REG_WDATA[`C2_AVG_OFF]) &&
			CORE_SUPPLY_ATTENUATOR_BYPASS ==
			$past(REG_WDATA[`C2_CORE_SUPPLY_ATTENUATOR_BYPASS_BYPASS]) &&
			SINGLE_CHANNEL_MODE == $past(REG_WDATA[`C2_SINGLE]) &&
			LOW_POWER_HALT == $past(REG_WDATA[`C2_HALT]);
	endproperty
	a_mode_bits: assert property (p_mode_bits)
		else $error("mode output differs from register");

	property p_single_sel;
		SINGLE_CHANNEL_MODE |=> SINGLE_CHANNEL_SEL_VALID ==
			($past(TACHOMETER_ONE_SEL) inside {`SEL_CORE, `SEL_MAIN,
			`SEL_REMOTE_ONE, `SEL_LOCAL, `SEL_REMOTE_TWO}) &&
			SINGLE_CHANNEL_SEL == $past(TACHOMETER_ONE_SEL);
	endproperty
	a_single_sel: assert property (p_single_sel)
		else $error("single channel selection wrong");

	property p_masked_local;
		(LIMIT_FLAGS == 7'h20 && STATUS_TWO_FLAGS == 8'h00) |=>
			SMBALERT_N == $past(state_r.alert_mask[`M1_LOCAL]);
	endproperty
	a_masked_local: assert property (p_masked_local)
		else $error("local mask not applied to alert");

	property p_masked_core;
		(LIMIT_FLAGS == 7'h02 && STATUS_TWO_FLAGS == 8'h00) |=>
			SMBALERT_N == $past(state_r.alert_mask[`M1_CORE]);
	endproperty
	a_masked_core: assert property (p_masked_core)
		else $error("core supply mask not applied to alert");

	property p_override;
		(LIMIT_FLAGS == 7'h00 && STATUS_TWO_FLAGS != 8'h00 &&
			ALERT_MASK_TWO == 8'hFF) |=>
			SMBALERT_N == $past(state_r.alert_mask[7]);
	endproperty
	a_override: assert property (p_override)
		else $error("status-2 override wrong");

	property p_alert_hold;
		(LIMIT_FLAGS[6] && !state_r.alert_mask[6] && !REG_WR) [*2] |=>
			!SMBALERT_N;
	endproperty
	a_alert_hold: assert property (p_alert_hold)
		else $error("alert released while flag stands");

	property p_power_up;
		$past(RESET) |-> state_r.local_offset == 8'h00 &&
			state_r.remote_two_offset == 8'h00 &&
			state_r.config_two == 8'h00 && state_r.alert_mask == 8'h00;
	endproperty
	a_power_up: assert property (p_power_up)
		else $error("register not zero after reset");

	property p_config_write;
		(!CFG1_LOCK && REG_WR && REG_ADDR == `ADDR_CONFIG_TWO) |=>
			state_r.config_two[7:4] == $past(REG_WDATA[7:4]) &&
			state_r.config_two[0] == $past(REG_WDATA[0]) &&
			state_r.config_two[3:1] == 3'h0;
	endproperty
	a_config_write: assert property (p_config_write)
		else $error("configuration write stored wrong bits");

	property p_mask_write;
		(!CFG1_LOCK && REG_WR && REG_ADDR == `ADDR_ALERT_MASK_ONE) |=>
			state_r.alert_mask[7:4] == $past(REG_WDATA[7:4]) &&
			state_r.alert_mask[2:1] == $past(REG_WDATA[2:1]) &&
			!state_r.alert_mask[0] && !state_r.alert_mask[3];
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write stored wrong bits");

	property p_local_write;
		(!CFG1_LOCK && REG_WR && REG_ADDR == `ADDR_LOCAL_OFFSET) |=>
			state_r.local_offset == $past(REG_WDATA);
	endproperty
	a_local_write: assert property (p_local_write)
		else $error("unlocked local offset write lost");

	property p_masked_main;
		(LIMIT_FLAGS == 7'h04 && STATUS_TWO_FLAGS == 8'h00) |=>
			SMBALERT_N == $past(state_r.alert_mask[`M1_MAIN]);
	endproperty
	a_masked_main: assert property (p_masked_main)
		else $error("main supply mask not applied to alert");

	property p_masked_remote_one;
		(LIMIT_FLAGS == 7'h10 && STATUS_TWO_FLAGS == 8'h00) |=>
			SMBALERT_N == $past(state_r.alert_mask[`M1_REMOTE_ONE]);
	endproperty
	a_masked_remote_one: assert property (p_masked_remote_one)
		else $error("remote one mask not applied to alert");

	property p_masked_remote_two;
		(LIMIT_FLAGS == 7'h40 && STATUS_TWO_FLAGS == 8'h00) |=>
			SMBALERT_N == $past(state_r.alert_mask[`M1_REMOTE_TWO]);
	endproperty
	a_masked_remote_two: assert property (p_masked_remote_two)
		else $error("remote two mask not applied to alert");

	// Flags without a mask bit can never be silenced
	property p_unmasked_always;
		(LIMIT_FLAGS[0] || LIMIT_FLAGS[3]) |=> !SMBALERT_N;
	endproperty
	a_unmasked_always: assert property (p_unmasked_always)
		else $error("unmaskable flag did not alert");

	property p_status_two_plain;
		(!state_r.alert_mask[`M1_STATUS_TWO_OVERRIDE] &&
			STATUS_TWO_FLAGS != 8'h00) |=> !SMBALERT_N;
	endproperty
	a_status_two_plain: assert property (p_status_two_plain)
		else $error("status-2 event did not alert");

	property p_alert_clear;
		(LIMIT_FLAGS == 7'h00 && STATUS_TWO_FLAGS == 8'h00) |=> SMBALERT_N;
	endproperty
	a_alert_clear: assert property (p_alert_clear)
		else $error("alert stands with no flag set");

	property p_no_mode_sel;
		!SINGLE_CHANNEL_MODE |=> !SINGLE_CHANNEL_SEL_VALID;
	endproperty
	a_no_mode_sel: assert property (p_no_mode_sel)
		else $error("selection valid outside single mode");

endmodule
`default_nettype wire

// ### tb/reg_host.sv
// Host model driving the byte-wide register port of the config bank
`timescale 1ns/100ps
`default_nettype none

module reg_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// Strobe one cycle; address and data held through the taking edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Answer stands one cycle only, so it is sampled just after that edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		ok = rvalid;
		d = rdata;
	endtask
endmodule

`default_nettype wire

// ### tb/thermal_config_bank_bench.sv
// Self-checking bench for the thermal config bank
`timescale 1ns/100ps
`default_nettype none

module thermal_config_bank_bench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic lock = 1'b0;
	logic [2:0] fan4 = 3'h0;
	logic [9:0] lraw = 10'h000;
	logic [9:0] rraw = 10'h000;
	logic [2:0] tsel = 3'h0;
	logic [3:0] fdin = 4'h0;
	logic flip = 1'b0;
	logic [6:0] lim = 7'h00;
	logic [7:0] s2 = 8'h00;
	logic [7:0] m2 = 8'h00;
	wire [7:0] addr;
	wire [7:0] wdata;
	wire [7:0] rdata;
	wire wr;
	wire rd;
	wire rvalid;
	wire [9:0] ltemp;
	wire [9:0] rtemp;
	wire averaging_disable;
	wire core_supply_attenuator_bypass;
	wire single;
	wire [2:0] sel;
	wire sel_ok;
	wire halt;
	wire [3:0] fdrv;
	wire alert_n;
	int fail_count = 0;
	int checked = 0;
	// Rows: mask1, limit flags, status-2, mask2, expected alert level
	logic [32:0] tbl [13] = '{
		{8'h00, 8'h02, 8'h00, 8'h00, 1'b0},
		{8'h02, 8'h02, 8'h00, 8'h00, 1'b1},
		{8'h04, 8'h04, 8'h00, 8'h00, 1'b1},
		{8'h04, 8'h02, 8'h00, 8'h00, 1'b0},
		{8'h70, 8'h70, 8'h00, 8'h00, 1'b1},
		{8'h70, 8'h01, 8'h00, 8'h00, 1'b0},
		{8'h10, 8'h10, 8'h00, 8'h00, 1'b1},
		{8'h20, 8'h20, 8'h00, 8'h00, 1'b1},
		{8'h00, 8'h20, 8'h00, 8'h00, 1'b0},
		{8'h00, 8'h40, 8'h00, 8'h00, 1'b0},
		{8'h00, 8'h00, 8'h01, 8'hFF, 1'b0},
		{8'h80, 8'h00, 8'h01, 8'hFF, 1'b1},
		{8'h80, 8'h00, 8'h01, 8'hFE, 1'b0}
	};

	always #5 clk = ~clk;

	reg_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rvalid(rvalid));

	thermal_config_bank dut (.CLK(clk), .RESET(reset), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .CFG1_LOCK(lock), .FAN_FOUR_WIRE(fan4),
		.LOCAL_TEMP_RAW(lraw), .REMOTE_TWO_TEMP_RAW(rraw),
		.LOCAL_TEMP(ltemp), .REMOTE_TWO_TEMP(rtemp),
		.TACHOMETER_ONE_SEL(tsel), .AVERAGING_DISABLE(averaging_disable),
		.CORE_SUPPLY_ATTENUATOR_BYPASS(core_supply_attenuator_bypass), .SINGLE_CHANNEL_MODE(single),
		.SINGLE_CHANNEL_SEL(sel), .SINGLE_CHANNEL_SEL_VALID(sel_ok),
		.FAN_DRIVE_IN(fdin), .PWM_POLARITY_FLIP(flip),
		.LOW_POWER_HALT(halt), .FAN_DRIVE(fdrv), .LIMIT_FLAGS(lim),
		.STATUS_TWO_FLAGS(s2), .ALERT_MASK_TWO(m2), .SMBALERT_N(alert_n));

	task automatic give_verdict();
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Read with the answer flag judged too
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.rd_reg(a, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk({8'h00, d}, {8'h00, exp});
	endtask

	task automatic sc_reset();
		tick(1);
		chk({15'h0000, alert_n}, 16'h0001);
		chk({12'h000, fdrv}, 16'h0000);
		rdc(8'h71, 8'h00);
		rdc(8'h72, 8'h00);
		rdc(8'h73, 8'h00);
		rdc(8'h74, 8'h00);
		rdc(8'h70, 8'h00);
	endtask

	task automatic sc_config();
		@(posedge clk);
		fan4 <= 3'b101;
		fdin <= 4'h5;
		flip <= 1'b1;
		host.wr_reg(8'h73, 8'hFE);
		rdc(8'h73, 8'hF0);
		host.wr_reg(8'h73, 8'hF1);
		rdc(8'h73, 8'hFB);
		tick(2);
		chk({13'h0000, averaging_disable, core_supply_attenuator_bypass, single}, 16'h0007);
		chk({11'h000, halt, fdrv}, 16'h001F);
		@(posedge clk);
		flip <= 1'b0;
		tick(2);
		chk({12'h000, fdrv}, 16'h0000);
		host.wr_reg(8'h73, 8'h00);
		tick(2);
		chk({11'h000, averaging_disable, core_supply_attenuator_bypass, single, halt, sel_ok}, 16'h0000);
		chk({12'h000, fdrv}, 16'h0005);
	endtask

	task automatic sc_select();
		host.wr_reg(8'h73, 8'h40);
		for (int c = 0; c < 8; c++) begin
			@(posedge clk);
			tsel <= c[2:0];
			tick(2);
			chk({13'h0000, sel}, c[15:0]);
			chk({15'h0000, sel_ok}, {15'h0000, c == 1 || c == 2 || c >= 5});
		end
	endtask

	task automatic sc_offset();
		@(posedge clk);
		// Mid-range readings so the adder's own sum check is exercised
		lraw <= 10'd300;
		rraw <= 10'd400;
		host.wr_reg(8'h71, 8'hFC);
		host.wr_reg(8'h72, 8'h04);
		rdc(8'h71, 8'hFC);
		rdc(8'h72, 8'h04);
		tick(2);
		chk({6'h00, ltemp}, 16'd292);
		chk({6'h00, rtemp}, 16'd408);
		@(posedge clk);
		lraw <= 10'd3;
		host.wr_reg(8'h71, 8'hF0);
		tick(2);
		chk({6'h00, ltemp}, 16'd0);
	endtask

	task automatic sc_alert();
		host.wr_reg(8'h74, 8'hFF);
		rdc(8'h74, 8'hF6);
		foreach (tbl[i]) begin
			host.wr_reg(8'h74, tbl[i][32:25]);
			@(posedge clk);
			lim <= tbl[i][23:17];
			s2 <= tbl[i][16:9];
			m2 <= tbl[i][8:1];
			tick(3);
			chk({15'h0000, alert_n}, {15'h0000, tbl[i][0]});
		end
		@(posedge clk);
		lim <= 7'h00;
		s2 <= 8'h00;
		tick(3);
		chk({15'h0000, alert_n}, 16'h0001);
	endtask

	task automatic sc_lock();
		// Everything is programmed before the lock goes on
		host.wr_reg(8'h71, 8'h11);
		@(posedge clk);
		lock <= 1'b1;
		for (int a = 8'h71; a <= 8'h74; a++) begin
			host.wr_reg(a[7:0], 8'hAA);
		end
		rdc(8'h71, 8'h11);
		rdc(8'h72, 8'h04);
		rdc(8'h73, 8'h40);
		rdc(8'h74, 8'h80);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		sc_reset();
		sc_config();
		sc_select();
		sc_offset();
		sc_alert();
		sc_lock();
		give_verdict();
	end

	// A hang is cut short here
	initial begin
		#500000;
		fail_count++;
		give_verdict();
	end
endmodule

`default_nettype wire
